// [hw/ufcc_cache_ctrl.sv]
`timescale 1ns/1ps
`include "ufcc_defs.svh"
module ufcc_cache_ctrl #(
  parameter bit LARGE = 1'b0  // larger part always uses 256 rows
) (
  input  logic                 clk,
  input  logic                 rst,
  input  logic                 ce,
  input  logic [7:0]           reg_addr,
  input  logic [31:0]          reg_wdata,
  input  logic                 reg_wr,
  input  logic                 reg_rd,
  output logic [31:0]          reg_rdata,
  input  logic                 lk_req,
  input  logic                 lk_write,
  input  logic [31:0]          lk_addr,
  output logic                 lk_done,
  output logic                 lk_hit,
  output ufcc_pkg::ufcc_way_t  lk_way,
  output logic                 lk_cacheable,
  output logic                 lk_wb,
  output ufcc_pkg::ufcc_way_t  lk_victim,
  output logic                 lk_victim_dirty,
  output ufcc_pkg::ufcc_tag_t  lk_victim_tag,
  output ufcc_pkg::ufcc_line_t lk_line,
  input  logic                 fill_req,
  input  logic [31:0]          fill_addr,
  input  ufcc_pkg::ufcc_way_t  fill_way,
  input  logic                 fill_dirty,
  input  ufcc_pkg::ufcc_line_t fill_line
);

  localparam int ENTRIES = 256;  // storage rows per way
  localparam int IDXW    = 8;    // row index width

  // control and size state
  logic                   ctl_ce;    // caching on
  logic                   ctl_wt;    // write-through for low and area three (code 6)
  logic                   ctl_cb;    // write-back for area one
  logic [2:0]             size_sel;  // capacity code
  logic                   big;       // large capacity in use
  logic                   flush_wr;  // flush requested this cycle

  // storage arrays
  logic [ENTRIES-1:0]     valid [4];            // line present flags
  logic [ENTRIES-1:0]     dirty [4];            // modified flags
  ufcc_pkg::ufcc_lru_t    lru   [ENTRIES];      // order bits per index
  ufcc_pkg::ufcc_tag_t    tags  [4][ENTRIES];   // tags, never reset
  ufcc_pkg::ufcc_line_t   data  [4][ENTRIES];   // lines, never reset

  // lookup decode
  logic [IDXW-1:0]        lk_idx;     // lookup row
  ufcc_pkg::ufcc_tag_t    lk_tag;     // lookup tag
  logic [IDXW-1:0]        fill_idx;   // fill row
  logic [3:0]             match;      // per-way valid tag match
  logic                   area_ok;    // area is cacheable
  logic                   area_wb;    // area runs write-back
  logic                   cach_c;     // access is cached
  logic                   hit_c;      // lookup hits
  ufcc_pkg::ufcc_way_t    hit_way;    // way that hit
  ufcc_pkg::ufcc_way_t    vic_c;      // victim of lookup row

  // row index from address; large capacity takes two more bits
  function automatic logic [IDXW-1:0] idx_of(input logic [31:0] a, input logic b);
    idx_of = b ? a[11:4] : {2'b00, a[9:4]};
  endfunction

  // tag from address bits 31 to 10 with shadow bits zeroed
  function automatic ufcc_pkg::ufcc_tag_t tag_of(input logic [31:0] a);
    tag_of = {3'h0, a[28:10]};
  endfunction

  // victim way from the order bits; each way owns three pair bits
  function automatic ufcc_pkg::ufcc_way_t lru_victim(input ufcc_pkg::ufcc_lru_t l);
    if (l[5] && l[4] && l[3]) begin
      lru_victim = 2'h0;
    end else if (!l[5] && l[2] && l[1]) begin
      lru_victim = 2'h1;
    end else if (!l[4] && !l[2] && l[0]) begin
      lru_victim = 2'h2;
    end else begin
      lru_victim = 2'h3;  // illegal patterns land here too
    end
  endfunction

  // make way w the most recent; only its three pair bits move
  function automatic ufcc_pkg::ufcc_lru_t lru_touch(input ufcc_pkg::ufcc_lru_t l,
                                                    input ufcc_pkg::ufcc_way_t w);
    lru_touch = l;
    case (w)
      2'h0: begin
        lru_touch[5] = 1'b0;
        lru_touch[4] = 1'b0;
        lru_touch[3] = 1'b0;
      end
      2'h1: begin
        lru_touch[5] = 1'b1;
        lru_touch[2] = 1'b0;
        lru_touch[1] = 1'b0;
      end
      2'h2: begin
        lru_touch[4] = 1'b1;
        lru_touch[2] = 1'b1;
        lru_touch[0] = 1'b0;
      end
      default: begin
        lru_touch[3] = 1'b1;
        lru_touch[1] = 1'b1;
        lru_touch[0] = 1'b1;
      end
    endcase
  endfunction

  assign big      = LARGE || (size_sel == `UFCC_SIZE_BIG);
  assign flush_wr = reg_wr && (reg_addr == `UFCC_CTRL_OFF) && reg_wdata[`UFCC_CF_BIT];
  assign lk_idx   = idx_of(lk_addr, big);
  assign lk_tag   = tag_of(lk_addr);
  assign fill_idx = idx_of(fill_addr, big);
  assign vic_c    = lru_victim(lru[lk_idx]);

  // area decode: cacheability and write policy
  always_comb begin
    area_ok = 1'b1;
    area_wb = !ctl_wt;
    case (lk_addr[31:29])
      `UFCC_AREA_ONE: begin
        area_wb = ctl_cb;
      end
      `UFCC_AREA_UNC, `UFCC_AREA_INT: begin
        area_ok = 1'b0;
        area_wb = 1'b0;
      end
      default: begin
        area_ok = 1'b1;
      end
    endcase
  end

  // four-way tag compare, hit only on a valid way
  always_comb begin
    hit_way = 2'h0;
    for (int w = 0; w < 4; w++) begin
      match[w] = valid[w][lk_idx] && (tags[w][lk_idx] == lk_tag);
      if (match[w]) begin
        hit_way = w[1:0];
      end
    end
    cach_c = ctl_ce && area_ok;
    hit_c  = cach_c && (|match);
  end

  // control and size registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_ce   <= `UFCC_CE_RST;
      ctl_wt   <= `UFCC_WT_RST;
      ctl_cb   <= `UFCC_CB_RST;
      size_sel <= `UFCC_SIZE_RST;
    end else if (ce && reg_wr) begin
      if (reg_addr == `UFCC_CTRL_OFF) begin
        ctl_ce <= reg_wdata[`UFCC_CE_BIT];
        ctl_wt <= reg_wdata[`UFCC_WT_BIT];
        ctl_cb <= reg_wdata[`UFCC_CB_BIT];
      end else if (reg_addr == `UFCC_SIZE_OFF) begin
        size_sel <= reg_wdata[`UFCC_SIZE_LSB +: `UFCC_SIZE_W];
      end
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= 32'h0000_0000;  // unmapped and reserved read zero
      if (reg_rd && reg_addr == `UFCC_CTRL_OFF) begin
        reg_rdata[`UFCC_CE_BIT] <= ctl_ce;
        reg_rdata[`UFCC_WT_BIT] <= ctl_wt;
        reg_rdata[`UFCC_CB_BIT] <= ctl_cb;  // flush bit stays zero
      end else if (reg_rd && reg_addr == `UFCC_SIZE_OFF) begin
        reg_rdata[`UFCC_SIZE_LSB +: `UFCC_SIZE_W] <= size_sel;
      end
    end
  end

  // valid flags: reset and flush clear, fill sets
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int w = 0; w < 4; w++) begin
        valid[w] <= '0;
      end
    end else if (ce) begin
      if (flush_wr) begin
        for (int w = 0; w < 4; w++) begin
          valid[w] <= '0;
        end
      end else if (fill_req) begin
        valid[fill_way][fill_idx] <= 1'b1;
      end
    end
  end

  // dirty flags: write hit in write-back marks, fill loads
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int w = 0; w < 4; w++) begin
        dirty[w] <= '0;
      end
    end else if (ce) begin
      if (flush_wr) begin
        for (int w = 0; w < 4; w++) begin
          dirty[w] <= '0;
        end
      end else begin
        if (lk_req && lk_write && hit_c && area_wb) begin
          dirty[hit_way][lk_idx] <= 1'b1;
        end
        if (fill_req) begin
          dirty[fill_way][fill_idx] <= fill_dirty;  // fill overrides
        end
      end
    end
  end

  // order bits: hit and fill make the way most recent
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < ENTRIES; i++) begin
        lru[i] <= `UFCC_LRU_RST;
      end
    end else if (ce) begin
      if (flush_wr) begin
        for (int i = 0; i < ENTRIES; i++) begin
          lru[i] <= `UFCC_LRU_RST;
        end
      end else begin
        if (lk_req && hit_c) begin
          lru[lk_idx] <= lru_touch(lru[lk_idx], hit_way);
        end
        if (fill_req) begin
          lru[fill_idx] <= lru_touch(lru[fill_idx], fill_way);
        end
      end
    end
  end

  // tags and lines: written only by a whole-line fill, never reset
  always_ff @(posedge clk) begin
    if (ce && fill_req) begin
      tags[fill_way][fill_idx] <= tag_of(fill_addr);
      data[fill_way][fill_idx] <= fill_line;
    end
  end

  // lookup answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      lk_done         <= 1'b0;
      lk_hit          <= 1'b0;
      lk_way          <= 2'h0;
      lk_cacheable    <= 1'b0;
      lk_wb           <= 1'b0;
      lk_victim       <= 2'h0;
      lk_victim_dirty <= 1'b0;
      lk_victim_tag   <= '0;
      lk_line         <= '0;
    end else if (ce) begin
      lk_done <= lk_req;
      if (lk_req) begin
        lk_hit          <= hit_c;
        lk_way          <= hit_way;
        lk_cacheable    <= cach_c;
        lk_wb           <= cach_c && area_wb;
        lk_victim       <= vic_c;
        lk_victim_dirty <= valid[vic_c][lk_idx] && dirty[vic_c][lk_idx];
        lk_victim_tag   <= tags[vic_c][lk_idx];
        lk_line         <= data[hit_way][lk_idx];
      end
    end
  end

  // checks
  a_flush_clears: assert property (
    @(posedge clk) disable iff (rst)
    ce && flush_wr |=> (valid[0] | valid[1] | valid[2] | valid[3]) == '0
                      && (dirty[0] | dirty[3]) == '0 && lru[0] == 6'h00)
    else $error("flush left state behind");

  a_regs_reserved_zero: assert property (
    @(posedge clk) disable iff (rst)
    ce && reg_rd |=> reg_rdata[31:3] == 29'h0)
    else $error("reserved or flush bit read nonzero");

  a_reset_state: assert property (
    @(posedge clk) disable iff (rst)
    $past(rst) |-> lru[0] == 6'h00 && valid[1] == '0 && !ctl_ce && size_sel == 3'h1)
    else $error("reset state wrong");

  a_uncached_area: assert property (
    @(posedge clk) disable iff (rst)
    ce && lk_req && (lk_addr[31:29] == 3'h5 || lk_addr[31:29] == 3'h7)
    |=> lk_done && !lk_cacheable && !lk_hit)
    else $error("uncached area treated as cached");

  a_disabled_no_hit: assert property (
    @(posedge clk) disable iff (rst)
    ce && lk_req && !ctl_ce |=> !lk_hit && !lk_cacheable)
    else $error("hit while cache disabled");

  a_area_one_policy: assert property (
    @(posedge clk) disable iff (rst)
    ce && lk_req && ctl_ce && lk_addr[31:29] == 3'h4 |=> lk_wb == $past(ctl_cb))
    else $error("area one policy wrong");

  a_low_area_policy: assert property (
    @(posedge clk) disable iff (rst)
    ce && lk_req && ctl_ce && !lk_addr[31] |=> lk_wb == !$past(ctl_wt))
    else $error("low area policy wrong");

  a_fill_then_hit: assert property (
    @(posedge clk) disable iff (rst)
    ce && fill_req && !flush_wr ##1 ce && lk_req && cach_c && !flush_wr
    && lk_addr[28:4] == $past(fill_addr[28:4]) && !$past(reg_wr)
    |=> lk_hit && lk_way == $past(fill_way, 2))
    else $error("filled line did not hit");

  a_fill_not_victim: assert property (
    @(posedge clk) disable iff (rst)
    ce && fill_req && !flush_wr ##1 ce && lk_req && !fill_req && !$past(reg_wr)
    && lk_idx == $past(fill_idx) |=> lk_victim != $past(fill_way, 2))
    else $error("most recent way chosen as victim");

  a_victim_way3: assert property (
    @(posedge clk) disable iff (rst)
    ce && lk_req && lru[lk_idx] == 6'h14 |=> lk_victim == 2'h3)
    else $error("pattern 010100 not way 3");

  a_victim_way0: assert property (
    @(posedge clk) disable iff (rst)
    ce && lk_req && lru[lk_idx] == 6'h39 |=> lk_victim == 2'h0)
    else $error("pattern 111001 not way 0");

  a_victim_way2: assert property (
    @(posedge clk) disable iff (rst)
    ce && lk_req && lru[lk_idx] == 6'h01 |=> lk_victim == 2'h2)
    else $error("pattern 000001 not way 2");

  a_victim_way1: assert property (
    @(posedge clk) disable iff (rst)
    ce && lk_req && lru[lk_idx] == 6'h1f |=> lk_victim == 2'h1)
    else $error("pattern 011111 not way 1");

endmodule // ufcc_cache_ctrl

// [inc/ufcc_defs.svh]
`ifndef UFCC_DEFS_SVH
`define UFCC_DEFS_SVH
// register byte offsets on the plain register port
`define UFCC_CTRL_OFF   8'h00
`define UFCC_SIZE_OFF   8'h04
// control register bit positions
`define UFCC_CE_BIT     0
`define UFCC_WT_BIT     1
`define UFCC_CB_BIT     2
`define UFCC_CF_BIT     3
// size register field position and width
`define UFCC_SIZE_LSB   0
`define UFCC_SIZE_W     3
// reset values
`define UFCC_CE_RST     1'b0
`define UFCC_WT_RST     1'b0
`define UFCC_CB_RST     1'b0
`define UFCC_SIZE_RST   3'h1
`define UFCC_LRU_RST    6'h00
// size code that selects the large capacity
`define UFCC_SIZE_BIG   3'h4
// area codes taken from address bits 31 to 29
`define UFCC_AREA_ONE   3'h4
`define UFCC_AREA_UNC   3'h5
`define UFCC_AREA_INT   3'h7
`endif

// [inc/ufcc_pkg.sv]
package ufcc_pkg;
  // one of the four ways
  typedef logic [1:0]   ufcc_way_t;
  // replacement-order bits of one index
  typedef logic [5:0]   ufcc_lru_t;
  // stored tag, upper three bits always zero
  typedef logic [21:0]  ufcc_tag_t;
  // one whole line of four words
  typedef logic [127:0] ufcc_line_t;
endpackage

// [tb/ufcc_bus_model.sv]
`timescale 1ns/1ps
// far side: returns one whole line for each request, one cycle long
module ufcc_bus_model (
  input  wire logic                  clk,
  input  wire logic                  go,
  input  wire logic [31:0]           addr,
  input  wire ufcc_pkg::ufcc_way_t   way,
  input  wire logic                  dirty,
  output logic                       fill_req,
  output logic [31:0]                fill_addr,
  output ufcc_pkg::ufcc_way_t        fill_way,
  output logic                       fill_dirty,
  output ufcc_pkg::ufcc_line_t       fill_line
);
  // quiet bus at time zero
  initial begin
    fill_req = 1'b0;
    fill_addr = 32'h0000_0000;
    fill_way = 2'h0;
    fill_dirty = 1'b0;
    fill_line = '0;
  end
  // between fills the bus toggles so stale values cannot pass for data
  always @(posedge clk) begin
    fill_req <= go;
    fill_addr <= go ? addr : ~fill_addr;
    fill_way <= go ? way : ~fill_way;
    fill_dirty <= go ? dirty : ~fill_dirty;
    // whole line in one transfer
    fill_line <= go ? {addr ^ 32'h0f0f_0f0f, ~addr, addr + 32'h0000_0001, addr} : ~fill_line;
  end
endmodule // ufcc_bus_model

// [tb/ufcc_cache_ctrl_tb.sv]
`timescale 1ns/1ps
`include "ufcc_defs.svh"
// self-checking bench for the cache control block
module ufcc_cache_ctrl_tb;
  logic                 clk, rst, ce, reg_wr, reg_rd, lk_req, lk_write, go, dirty;
  logic [7:0]           reg_addr;
  logic [31:0]          reg_wdata, reg_rdata, lk_addr, addr, fill_addr;
  logic                 lk_done, lk_hit, lk_cacheable, lk_wb, lk_victim_dirty;
  logic                 fill_req, fill_dirty;
  ufcc_pkg::ufcc_way_t  lk_way, lk_victim, way, fill_way;
  ufcc_pkg::ufcc_tag_t  lk_victim_tag;
  ufcc_pkg::ufcc_line_t lk_line, fill_line;
  int                   miscompares, comparisons;

  ufcc_cache_ctrl #(.LARGE(1'b0)) u_ufcc_cache_ctrl (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lk_req(lk_req),
    .lk_write(lk_write), .lk_addr(lk_addr), .lk_done(lk_done), .lk_hit(lk_hit),
    .lk_way(lk_way), .lk_cacheable(lk_cacheable), .lk_wb(lk_wb), .lk_victim(lk_victim),
    .lk_victim_dirty(lk_victim_dirty), .lk_victim_tag(lk_victim_tag), .lk_line(lk_line),
    .fill_req(fill_req), .fill_addr(fill_addr), .fill_way(fill_way),
    .fill_dirty(fill_dirty), .fill_line(fill_line));
  ufcc_bus_model u_ufcc_bus_model (
    .clk(clk), .go(go), .addr(addr), .way(way), .dirty(dirty), .fill_req(fill_req),
    .fill_addr(fill_addr), .fill_way(fill_way), .fill_dirty(fill_dirty),
    .fill_line(fill_line));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
  // compare of a register read
  task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // compare of a lookup result
  task automatic chk_lk(input string name, input logic [127:0] exp, input logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // line that the bus model returns for an address
  function automatic ufcc_pkg::ufcc_line_t line_of(input logic [31:0] x);
    return {x ^ 32'h0f0f_0f0f, ~x, x + 32'h0000_0001, x};
  endfunction
  // one-cycle register write
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle register read, data checked in the following cycle
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk_reg(name, exp, reg_rdata);
  endtask
  // ask the bus model for one line fill
  task automatic fill(input logic [31:0] a, input ufcc_pkg::ufcc_way_t w, input logic d);
    @(posedge clk);
    go <= 1'b1;
    addr <= a;
    way <= w;
    dirty <= d;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // one lookup, answer checked one cycle later
  task automatic lookup(input logic [31:0] a, input logic wr, input logic hit,
                        input ufcc_pkg::ufcc_way_t w);
    @(posedge clk);
    lk_req <= 1'b1;
    lk_addr <= a;
    lk_write <= wr;
    @(posedge clk);
    lk_req <= 1'b0;
    #1;
    chk_lk("done", 1'b1, lk_done);
    chk_lk("hit", hit, lk_hit);
    if (hit) chk_lk("way", w, lk_way);
  endtask
  // reset values, reserved bits, flush bit, unmapped address
  task automatic t_regs();
    reg_read(`UFCC_CTRL_OFF, 32'h0000_0000, "ctrl reset");
    reg_read(`UFCC_SIZE_OFF, 32'h0000_0001, "size reset");
    reg_read(8'h08, 32'h0000_0000, "unmapped");
    reg_write(`UFCC_CTRL_OFF, 32'hffff_fff7);
    reg_read(`UFCC_CTRL_OFF, 32'h0000_0007, "ctrl bits");
    reg_write(`UFCC_CTRL_OFF, 32'h0000_0008);
    reg_read(`UFCC_CTRL_OFF, 32'h0000_0000, "flush bit");
    reg_write(`UFCC_SIZE_OFF, 32'hffff_fff8);
    reg_read(`UFCC_SIZE_OFF, 32'h0000_0000, "size bits");
  endtask
  // clock enable low: a register write must be ignored
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    reg_write(`UFCC_CTRL_OFF, 32'h0000_0001);
    @(posedge clk);
    ce <= 1'b1;
    reg_read(`UFCC_CTRL_OFF, 32'h0000_0000, "frozen ctrl");
  endtask
  // two lines that share a row only in the small size
  task automatic t_size(input logic [2:0] code, input logic big);
    reg_write(`UFCC_SIZE_OFF, 32'(code));
    reg_write(`UFCC_CTRL_OFF, 32'h0000_0009);
    fill(32'h0000_0000, 2'h0, 1'b0);
    fill(32'h0000_0400, 2'h0, 1'b0);
    lookup(32'h0000_0000, 1'b0, big, 2'h0);
    lookup(32'h0000_0400, 1'b0, 1'b1, 2'h0);
    reg_write(`UFCC_CTRL_OFF, 32'h0000_0000);
  endtask
  // fill four ways of one row, then walk the replacement order
  // order bits move only by hits, fills, reset and flush, never by a raw pattern write
  task automatic t_lru();
    logic [31:0] a [4];
    ufcc_pkg::ufcc_way_t hw [5] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h0};
    ufcc_pkg::ufcc_way_t vw [5] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h1};
    logic dv [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    reg_write(`UFCC_CTRL_OFF, 32'h0000_000b);
    for (int i = 0; i < 4; i++) begin
      a[i] = 32'hc000_0050 | (32'(i) << 12);
      fill(a[i], 2'(i), i == 0);
    end
    for (int i = 0; i < 4; i++) begin
      lookup(a[i], 1'b1, 1'b1, 2'(i));
      chk_lk("victim", 128'(i), lk_victim);
      chk_lk("victim dirty", i == 0, lk_victim_dirty);
      chk_lk("victim tag", {3'h0, a[i][28:10]}, lk_victim_tag);
      chk_lk("line", line_of(a[i]), lk_line);
    end
    reg_write(`UFCC_CTRL_OFF, 32'h0000_0001);
    for (int i = 0; i < 5; i++) begin
      lookup(a[hw[i]], i == 0, 1'b1, hw[i]);
      chk_lk("victim", vw[i], lk_victim);
      chk_lk("victim dirty", dv[i], lk_victim_dirty);
    end
  endtask
  // flush drops a filled line: its lookup misses and the victim reads clean
  task automatic t_flush();
    reg_write(`UFCC_CTRL_OFF, 32'h0000_0009);
    lookup(32'hc000_1050, 1'b0, 1'b0, 2'h0);
    chk_lk("victim dirty", 1'b0, lk_victim_dirty);
  endtask
  // every area against every enable and policy setting
  task automatic t_policy();
    logic hit;
    for (int c = 0; c < 8; c++) begin
      for (int r = 0; r < 8; r++) begin
        hit = c[0] && r != 5 && r != 7;
        reg_write(`UFCC_CTRL_OFF, 32'(c));
        fill({3'(r), 29'h0000_0100}, 2'h0, 1'b0);
        lookup({3'(r), 29'h0000_0100}, 1'b0, hit, 2'h0);
        chk_lk("cacheable", hit, lk_cacheable);
        chk_lk("policy", hit && (r == 4 ? c[2] : !c[1]), lk_wb);
      end
    end
  endtask
  // counts, verdict and end of run
  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {rst, ce} = 2'b11;
    {reg_wr, reg_rd, lk_req, lk_write, go, dirty} = 6'h00;
    reg_addr = 8'h00;
    {reg_wdata, lk_addr, addr} = '0;
    way = 2'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_freeze();
    t_size(3'h1, 1'b0);
    t_size(`UFCC_SIZE_BIG, 1'b1);
    t_lru();
    t_flush();
    t_policy();
    test_done();
  end
endmodule // ufcc_cache_ctrl_tb
